// File: ebc_bus_control.sv
/*
  External bus control: software wait states, ready extension, direction,
  space selects and strobes, hold hand-over, output-off tri-state,
  read mode and clock output divider with PLL factor register.
  Assumes a single clock, inputs synchronous to it, and a register port
  whose read data appear one cycle after the read strobe.
*/
`default_nettype none
`include "ebc_defs.svh"

module ebc_bus_control (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [`EBC_ADDR_W-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [15:0] reg_rdata_o,
  input wire ebc_pkg::ebc_req_s req_i,
  output logic req_done_o,
  output logic req_busy_o,
  input wire logic ready_i,
  input wire logic hold_req_n_i,
  input wire logic output_off_n_i,
  output ebc_pkg::ebc_bus_s bus_o,
  output logic ctrl_oe_o,
  output logic addr_data_oe_o,
  output logic bus_grant_out_n,
  output logic grant_oe_o,
  output logic machine_clock_out,
  output logic consecutive_read_o,
  output logic [3:0] pll_int_o,
  output logic [1:0] pll_frac_o
);

  localparam ebc_pkg::ebc_bus_s BUS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  ebc_pkg::ebc_state_e state;
  ebc_pkg::ebc_state_e next_state;
  logic [15:0] bus_control_register;
  logic [15:0] wait_reg;
  logic [15:0] pll_reg;
  ebc_pkg::ebc_req_s cur;
  logic [2:0] wait_cnt;
  logic [2:0] waits;
  logic [1:0] div_cnt;
  logic clk_div;
  logic [1:0] machine_clock_out_divide_field;
  logic consecutive_read_sel;

  assign machine_clock_out_divide_field = bus_control_register[`EBC_CTRL_DIV_LSB +: 2];
  assign consecutive_read_sel = bus_control_register[`EBC_CTRL_CONSECUTIVE_READ_SEL_BIT];

  // Wait states per space: data [2:0], program [5:3], I/O [8:6].
  function automatic logic [2:0] waits_for(input logic [15:0] w, input ebc_pkg::ebc_space_e s);
    case (s)
      ebc_pkg::EBC_SP_PROG: waits_for = w[5:3];
      ebc_pkg::EBC_SP_IO: waits_for = w[8:6];
      default: waits_for = w[2:0];
    endcase
  endfunction

  // A zero integer falls back to a factor of one with the fraction cleared; otherwise the fraction is kept as written.
  function automatic logic [15:0] pll_legal(input logic [15:0] v);
    if (v[5:2] < `EBC_PLL_INT_MIN) begin
      pll_legal = {10'h000, `EBC_PLL_INT_MIN, 2'h0};
    end else begin
      pll_legal = {10'h000, v[5:0]};
    end
  endfunction

  assign waits = waits_for(wait_reg, cur.space);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_control_register <= `EBC_CTRL_RESET;
      wait_reg <= `EBC_WAIT_RESET;
      pll_reg <= `EBC_PLL_RESET;
    end else if (reg_write_i) begin
      case (reg_addr_i)
        `EBC_OFF_BUS_CTRL: bus_control_register <= {13'h0000, reg_wdata_i[2:0]};
        `EBC_OFF_WAIT: wait_reg <= {7'h00, reg_wdata_i[8:0]};
        `EBC_OFF_PLL: pll_reg <= pll_legal(reg_wdata_i);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_read_i) begin
      case (reg_addr_i)
        `EBC_OFF_BUS_CTRL: reg_rdata_o <= bus_control_register;
        `EBC_OFF_WAIT: reg_rdata_o <= wait_reg;
        `EBC_OFF_PLL: reg_rdata_o <= pll_reg;
        `EBC_OFF_STATUS: reg_rdata_o <= {11'h000, state};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ebc_pkg::EBC_IDLE: begin
        if (!hold_req_n_i) begin
          next_state = ebc_pkg::EBC_HOLD;
        end else if (req_i.valid) begin
          next_state = (waits_for(wait_reg, req_i.space) == 3'h0) ? ebc_pkg::EBC_LAST
                     : ebc_pkg::EBC_SWAIT;
        end
      end
      ebc_pkg::EBC_SWAIT: begin
        if (wait_cnt == 3'h1) begin
          // With two or more software waits, ready is first looked at on the edge that closes the last one.
          if (waits < `EBC_READY_MIN_WAITS || ready_i) begin
            next_state = ebc_pkg::EBC_LAST;
          end else begin
            next_state = ebc_pkg::EBC_RWAIT;
          end
        end
      end
      ebc_pkg::EBC_RWAIT: begin
        if (ready_i) begin
          next_state = ebc_pkg::EBC_LAST;
        end
      end
      ebc_pkg::EBC_LAST: next_state = ebc_pkg::EBC_IDLE;
      ebc_pkg::EBC_HOLD: begin
        if (hold_req_n_i) begin
          next_state = ebc_pkg::EBC_IDLE;
        end
      end
      default: next_state = ebc_pkg::EBC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ebc_pkg::EBC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur <= '0;
      wait_cnt <= 3'h0;
    end else if (state == ebc_pkg::EBC_IDLE && next_state != ebc_pkg::EBC_HOLD) begin
      cur <= req_i;
      wait_cnt <= waits_for(wait_reg, req_i.space);
    end else if (state == ebc_pkg::EBC_SWAIT) begin
      wait_cnt <= wait_cnt - 3'h1;
    end
  end

  // Bus pins are registered; selects and strobes span the whole access.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_o <= BUS_IDLE;
    end else if (next_state == ebc_pkg::EBC_IDLE || next_state == ebc_pkg::EBC_HOLD) begin
      bus_o <= BUS_IDLE;
    end else begin
      bus_o <= BUS_IDLE;
      if (state == ebc_pkg::EBC_IDLE) begin
        bus_o.dir_read <= ~req_i.write;
        bus_o.io_strobe_n <= req_i.space != ebc_pkg::EBC_SP_IO;
        bus_o.mem_strobe_n <= req_i.space == ebc_pkg::EBC_SP_IO;
        bus_o.data_sel_n <= req_i.space != ebc_pkg::EBC_SP_DATA;
        bus_o.prog_sel_n <= req_i.space != ebc_pkg::EBC_SP_PROG;
        bus_o.io_sel_n <= req_i.space != ebc_pkg::EBC_SP_IO;
      end else begin
        bus_o <= bus_o;
        // A count of two means the next cycle is the final software wait.
        bus_o.wait_complete_n <= ~(state == ebc_pkg::EBC_SWAIT && wait_cnt == 3'h2);
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_grant_out_n <= 1'b1;
      ctrl_oe_o <= 1'b0;
      addr_data_oe_o <= 1'b0;
      grant_oe_o <= 1'b0;
    end else begin
      bus_grant_out_n <= next_state != ebc_pkg::EBC_HOLD;
      grant_oe_o <= output_off_n_i;
      ctrl_oe_o <= output_off_n_i && next_state != ebc_pkg::EBC_HOLD;
      addr_data_oe_o <= output_off_n_i && next_state != ebc_pkg::EBC_HOLD
                        && next_state != ebc_pkg::EBC_IDLE;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_done_o <= 1'b0;
      req_busy_o <= 1'b0;
    end else begin
      req_done_o <= state == ebc_pkg::EBC_LAST;
      req_busy_o <= next_state != ebc_pkg::EBC_IDLE;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      consecutive_read_o <= 1'b0;
      pll_int_o <= 4'h1;
      pll_frac_o <= 2'h0;
    end else begin
      consecutive_read_o <= consecutive_read_sel;
      pll_int_o <= pll_reg[5:2];
      pll_frac_o <= pll_reg[1:0];
    end
  end

  // Divide by two toggles every cycle; by four toggles every second cycle.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_cnt <= 2'h0;
      clk_div <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
      if (machine_clock_out_divide_field == `EBC_DIV_FOUR) begin
        clk_div <= div_cnt[0] ? ~clk_div : clk_div;
      end else begin
        clk_div <= ~clk_div;
      end
    end
  end

  // Undivided setting toggles the output flop every cycle, so it runs at half the clock rate.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      machine_clock_out <= 1'b0;
    end else begin
      machine_clock_out <= (machine_clock_out_divide_field == `EBC_DIV_NONE) ? ~machine_clock_out
                           : clk_div;
    end
  end

  property p_ready_ignored;
    @(posedge clk_i) disable iff (reset_i)
      (state == ebc_pkg::EBC_SWAIT && wait_cnt == 3'h1 && waits < 3'h2)
      |=> state == ebc_pkg::EBC_LAST;
  endproperty
  a_ready_ignored: assert property (p_ready_ignored) else $error("ready used too early");

  property p_ready_ext;
    @(posedge clk_i) disable iff (reset_i)
      (state == ebc_pkg::EBC_RWAIT && !ready_i) |=> state == ebc_pkg::EBC_RWAIT;
  endproperty
  a_ready_ext: assert property (p_ready_ext) else $error("ready low not extended");

  property p_wait_rdy;
    @(posedge clk_i) disable iff (reset_i)
      (state == ebc_pkg::EBC_SWAIT && wait_cnt == 3'h1
       && waits >= `EBC_READY_MIN_WAITS && !ready_i) |=> state == ebc_pkg::EBC_RWAIT;
  endproperty
  a_wait_rdy: assert property (p_wait_rdy) else $error("ready low at last wait");

  property p_grant;
    @(posedge clk_i) disable iff (reset_i)
      (state == ebc_pkg::EBC_HOLD) |-> (!bus_grant_out_n && !addr_data_oe_o);
  endproperty
  a_grant: assert property (p_grant) else $error("hold grant wrong");

  property p_hold_ctrl;
    @(posedge clk_i) disable iff (reset_i)
      (state == ebc_pkg::EBC_HOLD) |-> !ctrl_oe_o;
  endproperty
  a_hold_ctrl: assert property (p_hold_ctrl) else $error("control driven in hold");

  property p_off;
    @(posedge clk_i) disable iff (reset_i)
      !output_off_n_i |=> (!ctrl_oe_o && !grant_oe_o);
  endproperty
  a_off: assert property (p_off) else $error("outputs driven with off low");

  property p_idle_dir;
    @(posedge clk_i) disable iff (reset_i)
      (state == ebc_pkg::EBC_IDLE) |-> (bus_o.dir_read && bus_o.io_strobe_n);
  endproperty
  a_idle_dir: assert property (p_idle_dir) else $error("idle pins not high");

  property p_io_mem;
    @(posedge clk_i) disable iff (reset_i)
      !(bus_o.io_strobe_n == 1'b0 && bus_o.mem_strobe_n == 1'b0);
  endproperty
  a_io_mem: assert property (p_io_mem) else $error("both strobes low");

  property p_wc;
    @(posedge clk_i) disable iff (reset_i)
      (bus_o.wait_complete_n == 1'b0)
      == (state == ebc_pkg::EBC_SWAIT && wait_cnt == 3'h1 && waits >= `EBC_READY_MIN_WAITS);
  endproperty
  a_wc: assert property (p_wc) else $error("wait complete misplaced");

endmodule

`default_nettype wire

// File: ebc_defs.svh
/*
  Constants of the external bus control block: register offsets, field
  positions, reset values and counts.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef EBC_DEFS_SVH
`define EBC_DEFS_SVH

`define EBC_ADDR_W 4
`define EBC_OFF_BUS_CTRL 4'h0
`define EBC_OFF_WAIT 4'h1
`define EBC_OFF_PLL 4'h2
`define EBC_OFF_STATUS 4'h3
`define EBC_CTRL_CONSECUTIVE_READ_SEL_BIT 0
`define EBC_CTRL_DIV_LSB 1
`define EBC_CTRL_RESET 16'h0004
`define EBC_DIV_NONE 2'h0
`define EBC_DIV_FOUR 2'h2
`define EBC_WAIT_RESET 16'h0000
`define EBC_PLL_RESET 16'h0004
`define EBC_READY_MIN_WAITS 3'h2
`define EBC_PLL_INT_MAX 4'hF
`define EBC_PLL_INT_MIN 4'h1

`endif

// File: ebc_far_side.sv
/*
  Far-side model of the external bus: a slow memory or I/O device that
  drives ready, optionally looped back from the wait-complete pin.
  Assumes the bus control block's clock and registered bus outputs.
*/
`default_nettype none

module ebc_far_side (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire ebc_pkg::ebc_bus_s bus_i,
  input wire logic oe_i,
  input wire logic [3:0] stall_i,
  input wire logic loop_i,
  output logic ready_o
);
  logic [3:0] cnt;
  logic active;

  // Released strobes float high on the board, so an undriven bus is idle.
  assign active = oe_i && !(bus_i.mem_strobe_n && bus_i.io_strobe_n);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= 4'h0;
    end else if (!active) begin
      cnt <= 4'h0;
    end else if (cnt != 4'hF) begin
      cnt <= cnt + 4'h1;
    end
  end

  // A slow device keeps ready low for its first stall cycles of an access.
  assign ready_o = loop_i ? bus_i.wait_complete_n : (cnt >= stall_i);
endmodule

`default_nettype wire

// File: ebc_pkg.sv
/*
  Types of the external bus control block.
  Assumes ebc_defs.svh is on the include path.
*/
`default_nettype none
`include "ebc_defs.svh"

package ebc_pkg;

  typedef enum logic [1:0] {
    EBC_SP_DATA = 2'h0,
    EBC_SP_PROG = 2'h1,
    EBC_SP_IO = 2'h2
  } ebc_space_e;

  typedef struct packed {
    logic valid;
    logic write;
    ebc_space_e space;
  } ebc_req_s;

  // Bus-side strobes and selects, all active low, plus the read direction, high for a read.
  typedef struct packed {
    logic dir_read;
    logic mem_strobe_n;
    logic io_strobe_n;
    logic data_sel_n;
    logic prog_sel_n;
    logic io_sel_n;
    logic wait_complete_n;
  } ebc_bus_s;

  typedef enum logic [4:0] {
    EBC_IDLE = 5'h01,
    EBC_SWAIT = 5'h02,
    EBC_RWAIT = 5'h04,
    EBC_LAST = 5'h08,
    EBC_HOLD = 5'h10
  } ebc_state_e;

endpackage

`default_nettype wire

// File: external_bus_control_test.sv
/*
  Self-checking bench of the external bus control block.
  Assumes ebc_pkg, ebc_far_side and the design are compiled before it.
*/
`default_nettype none
`include "ebc_defs.svh"

module external_bus_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [`EBC_ADDR_W-1:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_write_i = 1'b0, reg_read_i = 1'b0, hold_req_n_i = 1'b1, output_off_n_i = 1'b1;
  logic loop = 1'b0;
  logic [3:0] stall = 4'h0;
  ebc_pkg::ebc_req_s req_i = '0;
  ebc_pkg::ebc_bus_s bus_o;
  logic [15:0] reg_rdata_o;
  logic [3:0] pll_int_o;
  logic [1:0] pll_frac_o;
  logic req_done_o, req_busy_o, ready_i, ctrl_oe_o, addr_data_oe_o, bus_grant_out_n;
  logic grant_oe_o, machine_clock_out, consecutive_read_o;
  int n_mismatch = 0, total_checks = 0, lat, wc;

  ebc_bus_control i_dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .req_i(req_i), .req_done_o(req_done_o),
    .req_busy_o(req_busy_o), .ready_i(ready_i), .hold_req_n_i(hold_req_n_i),
    .output_off_n_i(output_off_n_i), .bus_o(bus_o), .ctrl_oe_o(ctrl_oe_o),
    .addr_data_oe_o(addr_data_oe_o), .bus_grant_out_n(bus_grant_out_n),
    .grant_oe_o(grant_oe_o), .machine_clock_out(machine_clock_out),
    .consecutive_read_o(consecutive_read_o), .pll_int_o(pll_int_o), .pll_frac_o(pll_frac_o));
  ebc_far_side i_far (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_o), .oe_i(ctrl_oe_o),
    .stall_i(stall), .loop_i(loop), .ready_o(ready_i));

  always #4 clk_i = ~clk_i;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask

  // One access; n is the cycle of the done pulse, w the cycle of wait-complete low.
  task automatic acc(input logic w_en, input logic [1:0] sp, output int n, output int w);
    logic [5:0] e;
    @(posedge clk_i);
    req_i <= '{valid: 1'b1, write: w_en, space: ebc_pkg::ebc_space_e'(sp)};
    @(posedge clk_i);
    req_i.valid <= 1'b0;
    n = 1;
    w = 0;
    e = {!w_en, sp == 2'h2, sp != 2'h2, sp != 2'h0, sp != 2'h1, sp != 2'h2};
    #1 chk({req_busy_o, addr_data_oe_o, bus_o[6:1]}, {2'h3, e});
    while (req_done_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      #1 n++;
      if (bus_o.wait_complete_n === 1'b0 && w == 0) w = n;
    end
    chk({req_busy_o, addr_data_oe_o, bus_o}, 16'h007F);
  endtask

  task automatic rises(output int r);
    logic prev;
    r = 0;
    prev = machine_clock_out;
    repeat (16) begin
      @(posedge clk_i);
      #1 if (machine_clock_out === 1'b1 && prev === 1'b0) r++;
      prev = machine_clock_out;
    end
  endtask

  // The whole sequence needs about 130 cycles; nearly forty times that is a hang.
  initial begin
    #40000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rdc(`EBC_OFF_BUS_CTRL, 16'h0004);
    rdc(`EBC_OFF_WAIT, 16'h0000);
    rdc(`EBC_OFF_PLL, 16'h0004);
    rdc(4'hF, 16'h0000);
    rises(lat);
    chk_n(lat, 4);
    chk({pll_int_o, pll_frac_o}, 16'h0004);
    wr(`EBC_OFF_PLL, 16'h003F);
    chk({pll_int_o, pll_frac_o}, 16'h003F);
    wr(`EBC_OFF_PLL, 16'h0002);
    chk({pll_int_o, pll_frac_o}, 16'h0004);
    wr(`EBC_OFF_BUS_CTRL, 16'h0001);
    chk(consecutive_read_o, 16'h0001);
    wr(`EBC_OFF_BUS_CTRL, 16'h0000);
    chk(consecutive_read_o, 16'h0000);
    rises(lat);
    chk_n(lat, 8);
    for (int i = 0; i < 6; i++) begin
      acc(i[0], i[2:1], lat, wc);
      chk_n(lat, 2);
    end
    stall <= 4'h3;
    wr(`EBC_OFF_WAIT, 16'h0001);
    acc(1'b0, 2'h0, lat, wc);
    chk_n(lat, 3);
    wr(`EBC_OFF_WAIT, 16'h0002);
    acc(1'b0, 2'h0, lat, wc);
    chk_n(lat, 6);
    stall <= 4'h2;
    wr(`EBC_OFF_WAIT, 16'h0003);
    acc(1'b1, 2'h0, lat, wc);
    chk_n(lat, 5);
    stall <= 4'h0;
    loop <= 1'b1;
    wr(`EBC_OFF_WAIT, 16'h0080);
    acc(1'b1, 2'h2, lat, wc);
    chk_n(wc, 2);
    chk_n(lat, 5);
    loop <= 1'b0;
    @(posedge clk_i);
    hold_req_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk({bus_grant_out_n, ctrl_oe_o, addr_data_oe_o, grant_oe_o}, 16'h0001);
    @(posedge clk_i);
    req_i <= '{valid: 1'b1, write: 1'b0, space: ebc_pkg::EBC_SP_DATA};
    repeat (4) @(posedge clk_i);
    #1 chk({req_done_o, bus_o.mem_strobe_n}, 16'h0001);
    @(posedge clk_i);
    req_i.valid <= 1'b0;
    hold_req_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk({bus_grant_out_n, ctrl_oe_o}, 16'h0003);
    acc(1'b0, 2'h1, lat, wc);
    chk_n(lat, 2);
    @(posedge clk_i);
    output_off_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk({ctrl_oe_o, grant_oe_o}, 16'h0000);
    @(posedge clk_i);
    output_off_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk({ctrl_oe_o, grant_oe_o}, 16'h0003);
    end_sim();
  end
endmodule

`default_nettype wire
